// *** rtl/ihb_device.sv ***
`timescale 1ns/1ps
// Functional notes
// R1 - queue endian bit, four copies set together
// R2 - per-pair endian bits, copies set together
// R3 - write cycle: cs+wr or enable+direction
// R4 - pointer/config latch on trailing edge
// R5 - word or byte update, no 16-bit bytes
// R6 - writes dropped after init until read
// R7 - writes dropped in low power until read
// R8 - reads decode live address, endian lane
// R9 - two or four accesses make dword
// R10 - separate assembly per window and queue
// R11 - leading edge captures pointer address
// R12 - leading edge captures address, queue select
// R13 - trailing edge stores swapped lane
// R14 - host writes each lane once
// R15 - no shared register, no mixed direction
// R16 - counter advance, then 32-bit internal write
// R17 - counters cleared outside fully on
// R18 - host map offsets, queue select override
// R19 - 16-bit pointer, reset pattern
// R20 - byte or word host addressing
// R21 - terminal count two or four, wraps
module ihb_device
    import ihb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    ihb_if.dev bus,
    input wire logic initDone,
    input wire logic fullyOnPowerState,
    output logic intWrValid,
    output logic [15:0] intWrAddr,
    output logic [31:0] intWrData,
    output logic intWrQueue,
    output logic [31:0] endianConfig,
    output logic writesArmed
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] csS, rdS, wrS, enS, dirS;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            csS <= 2'h3;
            rdS <= 2'h3;
            wrS <= 2'h3;
            enS <= 2'h0;
            dirS <= 2'h0;
        end else begin
            csS <= {csS[0], bus.csN};
            rdS <= {rdS[0], bus.rdN};
            wrS <= {wrS[0], bus.wrN};
            enS <= {enS[0], bus.strobeEnable};
            dirS <= {dirS[0], bus.rdWrN};
        end
    end
    logic [4:0] addrS1, addrS2;
    logic [15:0] dinS1, dinS2;
    logic qselS1, qselS2, wideS1, wideS2;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            addrS1 <= 5'h00;
            addrS2 <= 5'h00;
            dinS1 <= 16'h0000;
            dinS2 <= 16'h0000;
            qselS1 <= 1'b0;
            qselS2 <= 1'b0;
            wideS1 <= 1'b0;
            wideS2 <= 1'b0;
        end else begin
            addrS1 <= bus.addr;
            addrS2 <= addrS1;
            dinS1 <= bus.hostDout;
            dinS2 <= dinS1;
            qselS1 <= bus.queueDirectSelect;
            qselS2 <= qselS1;
            wideS1 <= bus.busWide;
            wideS2 <= wideS1;
        end
    end

    // ------------------------------------------------------------
    // cycle detection
    // ------------------------------------------------------------
    logic wrAct, rdAct, wrAct_q, rdAct_q, wrLead, wrTrail, rdLead;
    logic [4:0] hAddr;
    always_comb begin
        wrAct = (!csS[1] && !wrS[1]) || (enS[1] && !dirS[1]); // R3
        rdAct = (!csS[1] && !rdS[1]) || (enS[1] && dirS[1]);
        hAddr = wideS2 ? {addrS2[4:1], 1'b0} : addrS2; // R20
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wrAct_q <= 1'b0;
            rdAct_q <= 1'b0;
        end else begin
            wrAct_q <= wrAct;
            rdAct_q <= rdAct;
        end
    end
    assign wrLead = wrAct && !wrAct_q;
    assign wrTrail = !wrAct && wrAct_q; // R4
    assign rdLead = rdAct && !rdAct_q;

    // write gate: closed after init and outside fully on, reopened by a read
    logic initDone_q;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            writesArmed <= 1'b0;
            initDone_q <= 1'b0;
        end else begin
            initDone_q <= initDone;
            if (!fullyOnPowerState || (initDone && !initDone_q)) begin
                writesArmed <= 1'b0; // R6 R7
            end else if (rdLead) begin
                writesArmed <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // leading-edge capture
    // ------------------------------------------------------------
    logic [4:0] capAddr_q;
    logic capQsel_q, capArmed_q;
    logic [15:0] capIaddr_q;
    logic [15:0] ptr_q [3];
    logic capPath;
    logic [1:0] capIdx;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            capAddr_q <= 5'h00;
            capQsel_q <= 1'b0;
            capIaddr_q <= 16'h0000;
            capArmed_q <= 1'b0;
        end else if (wrLead) begin
            capAddr_q <= hAddr; // R12
            capQsel_q <= qselS2; // R12
            capIaddr_q <= ptr_q[hAddr[4:3] == 2'h3 ? 2'h0 : hAddr[4:3]]; // R11
            capArmed_q <= writesArmed;
        end
    end
    // decode the captured address into a path; config shares bit 2 with the windows,
    // so it is kept off the queue path or it would feed the queue assembly
    always_comb begin
        capPath = capQsel_q || (capAddr_q[2] && capAddr_q[4:3] != 2'h3)
            || (capAddr_q[4:2] == OFS_QUEUE[4:2]); // R18 R10
        capIdx = (capQsel_q || capAddr_q[4:2] == OFS_QUEUE[4:2]) ? PATH_QUEUE
            : capAddr_q[4:3];
    end

    // ------------------------------------------------------------
    // lane selection
    // ------------------------------------------------------------
    logic [31:0] cfg_q;
    logic capBig, liveBig;
    logic [3:0] wrLaneEn, rdLaneEn;
    logic [1:0] wrBase, rdBase;
    logic liveQueue;
    assign liveQueue = qselS2 || hAddr[4:2] == OFS_QUEUE[4:2];
    assign capBig = cfg_q[capIdx == PATH_QUEUE ? CFG_QUEUE_BIT : 32'(capIdx)];
    assign liveBig = cfg_q[hAddr[4:2] == OFS_CFG[4:2] ? 0
        : (liveQueue ? CFG_QUEUE_BIT : 32'(hAddr[4:3]))];
    ihb_lane_swap uWrSwap (
        .wide(wideS2),
        .bigEnd(capBig),
        .lowAddr(capAddr_q[1:0]),
        .laneEn(wrLaneEn),
        .laneBase(wrBase)
    );
    ihb_lane_swap uRdSwap (
        .wide(wideS2),
        .bigEnd(liveBig),
        .lowAddr(hAddr[1:0]),
        .laneEn(rdLaneEn),
        .laneBase(rdBase)
    );
    logic [31:0] wrWord;
    // big endian swaps bytes inside a 16-bit word as well
    assign wrWord = (wideS2 && capBig) ? {2{dinS2[7:0], dinS2[15:8]}}
        : (wideS2 ? {2{dinS2}} : {4{dinS2[7:0]}}); // R13
    logic doWrite;
    assign doWrite = wrTrail && capArmed_q && writesArmed
        && !(wideS2 && capAddr_q[0]); // R5

    // ------------------------------------------------------------
    // pointer and configuration registers
    // ------------------------------------------------------------
    logic [31:0] cfgNew;
    always_comb begin
        cfgNew = cfg_q;
        for (int b = 0; b < 4; b++) begin
            if (wrLaneEn[b]) cfgNew[b*8 +: 8] = wrWord[b*8 +: 8];
        end
        cfgNew = cfgNew & CFG_RW_MASK;
        for (int n = 0; n < 4; n++) begin
            // any copy set sets all copies
            if (cfgNew[n] | cfgNew[n+8] | cfgNew[n+16] | cfgNew[n+24]) begin
                for (int k = 0; k < 4; k++) cfgNew[n + k*CFG_SHADOW_STEP] = 1'b1; // R1 R2
            end
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_q <= CFG_RESET;
        end else if (doWrite && !capQsel_q && capAddr_q[4:2] == OFS_CFG[4:2]) begin
            cfg_q <= cfgNew; // R4
        end
    end
    assign endianConfig = cfg_q;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gPtr
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    ptr_q[g] <= PTR_RESET; // R19
                end else if (doWrite && !capPath && capAddr_q[4:3] == 2'(g)) begin
                    for (int b = 0; b < 2; b++) begin
                        if (wrLaneEn[b]) ptr_q[g][b*8 +: 8] <= wrWord[b*8 +: 8]; // R5
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // dword assembly, one per path
    // ------------------------------------------------------------
    logic [31:0] asm_q [4];
    logic [1:0] cnt_q [4];
    logic fire;
    assign fire = doWrite && capPath
        && (cnt_q[capIdx] == (wideS2 ? 2'h1 : 2'h3)); // R21
    generate
        for (g = 0; g < 4; g++) begin : gAsm
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    cnt_q[g] <= 2'h0;
                    asm_q[g] <= 32'h0;
                end else if (!fullyOnPowerState) begin
                    cnt_q[g] <= 2'h0; // R17
                end else if (doWrite && capPath && capIdx == 2'(g)) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wrLaneEn[b]) asm_q[g][b*8 +: 8] <= wrWord[b*8 +: 8]; // R10 R13
                    end
                    cnt_q[g] <= fire ? 2'h0 : cnt_q[g] + 2'h1; // R9 R16
                end
            end
        end
    endgenerate
    // internal write one cycle after the last lane lands
    logic pend_q;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pend_q <= 1'b0;
            intWrValid <= 1'b0;
            intWrAddr <= 16'h0;
            intWrQueue <= 1'b0;
        end else begin
            pend_q <= fire;
            intWrValid <= pend_q; // R16
            if (fire) begin
                intWrAddr <= capIdx == PATH_QUEUE ? QUEUE_IADDR : capIaddr_q;
                intWrQueue <= capIdx == PATH_QUEUE;
            end
        end
    end
    logic [1:0] lastIdx_q;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) lastIdx_q <= 2'h0;
        else if (fire) lastIdx_q <= capIdx;
    end
    assign intWrData = asm_q[lastIdx_q];

    // ------------------------------------------------------------
    // read path for pointer and configuration registers
    // ------------------------------------------------------------
    logic [31:0] rdWord;
    always_comb begin
        if (hAddr[4:2] == OFS_CFG[4:2]) rdWord = cfg_q;
        else if (!hAddr[2] && hAddr[4:3] != 2'h3) rdWord = {16'h0, ptr_q[hAddr[4:3]]};
        else rdWord = 32'h0; // data windows are not read here
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bus.devDout <= 16'h0;
            bus.devDoutOeN <= 1'b1;
        end else begin
            bus.devDoutOeN <= !(rdAct && fullyOnPowerState);
            if (wideS2) begin
                bus.devDout <= liveBig ? {rdWord[rdBase*8 +: 8], rdWord[rdBase*8+8 +: 8]}
                    : rdWord[rdBase*8 +: 16]; // R8
            end else begin
                bus.devDout <= {8'h0, rdWord[rdBase*8 +: 8]}; // R8
            end
        end
    end
endmodule

// *** rtl/ihb_host.sv ***
`timescale 1ns/1ps
// host end: turns a register command into one strobed bus cycle
module ihb_host
    import ihb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    ihb_if.host bus,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata
);
    typedef enum {IHB_IDLE, IHB_STROBE, IHB_GAP} ihb_state_t;
    ihb_state_t state_q;
    logic [4:0] tAddr_q;
    logic [15:0] tData_q, rdCap_q, rdS1, rdS2;
    logic ctlRead_q, ctlWide_q, ctlQsel_q, ctlEnb_q, busy;
    logic [7:0] cnt_q;
    // ------------------------------------------------------------
    // command registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tAddr_q <= 5'h0;
            tData_q <= 16'h0;
            ctlRead_q <= 1'b0;
            ctlWide_q <= 1'b0;
            ctlQsel_q <= 1'b0;
            ctlEnb_q <= 1'b0;
        end else if (regWr) begin
            if (regAddr == CMD_ADDR_OFS) tAddr_q <= regWdata[4:0];
            if (regAddr == CMD_WDATA_OFS) tData_q <= regWdata[15:0];
            if (regAddr == CMD_CTRL_OFS) begin
                ctlRead_q <= regWdata[CTRL_READ_BIT];
                ctlWide_q <= regWdata[CTRL_WIDE_BIT];
                ctlQsel_q <= regWdata[CTRL_QSEL_BIT];
                ctlEnb_q <= regWdata[CTRL_ENB_BIT];
            end
        end
    end
    // one strobe then a gap; a go while busy is ignored
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= IHB_IDLE;
            cnt_q <= 8'h0;
        end else begin
            case (state_q)
                IHB_IDLE: begin
                    if (regWr && regAddr == CMD_CTRL_OFS && regWdata[CTRL_GO_BIT]) begin
                        state_q <= IHB_STROBE;
                        cnt_q <= 8'(STROBE_CYC + 3);
                    end
                end
                IHB_STROBE: begin
                    cnt_q <= cnt_q - 8'h1;
                    if (cnt_q == 8'h1) begin
                        state_q <= IHB_GAP;
                        cnt_q <= 8'(GAP_CYC + 3);
                    end
                end
                IHB_GAP: begin
                    cnt_q <= cnt_q - 8'h1;
                    if (cnt_q == 8'h1) state_q <= IHB_IDLE;
                end
                default: state_q <= IHB_IDLE;
            endcase
        end
    end
    assign busy = state_q != IHB_IDLE;
    // device data captured at the end of a read strobe
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdS1 <= 16'h0;
            rdS2 <= 16'h0;
            rdCap_q <= 16'h0;
        end else begin
            rdS1 <= bus.devDout;
            rdS2 <= rdS1;
            if (state_q == IHB_STROBE && cnt_q == 8'h1 && ctlRead_q) rdCap_q <= rdS2;
        end
    end
    // bus pins driven from state: cs/rd/wr style, or enable with direction
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bus.csN <= 1'b1;
            bus.rdN <= 1'b1;
            bus.wrN <= 1'b1;
            bus.strobeEnable <= 1'b0;
            bus.rdWrN <= 1'b1;
            bus.queueDirectSelect <= 1'b0;
            bus.addr <= 5'h0;
            bus.hostDout <= 16'h0;
            bus.hostDoutOeN <= 1'b1;
            bus.busWide <= 1'b0;
        end else begin
            bus.csN <= !(state_q == IHB_STROBE && !ctlEnb_q);
            bus.rdN <= !(state_q == IHB_STROBE && !ctlEnb_q && ctlRead_q);
            bus.wrN <= !(state_q == IHB_STROBE && !ctlEnb_q && !ctlRead_q);
            bus.strobeEnable <= state_q == IHB_STROBE && ctlEnb_q; // R3
            bus.rdWrN <= ctlRead_q; // R3
            bus.queueDirectSelect <= ctlQsel_q;
            bus.addr <= tAddr_q;
            bus.hostDout <= tData_q;
            bus.hostDoutOeN <= ctlRead_q || !busy;
            bus.busWide <= ctlWide_q;
        end
    end
    // status and read-back, one cycle after the strobe
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) regRdata <= 32'h0;
        else if (regRd) regRdata <= regAddr == CMD_STAT_OFS ? {31'h0, busy}
            : (regAddr == CMD_WDATA_OFS ? {16'h0, rdCap_q} : 32'h0);
    end
endmodule

// *** rtl/ihb_if.sv ***
`timescale 1ns/1ps
interface ihb_if;
    logic csN;
    logic rdN;
    logic wrN;
    logic strobeEnable;
    logic rdWrN;
    logic queueDirectSelect;
    logic [4:0] addr;
    logic [15:0] hostDout;
    logic hostDoutOeN;
    logic [15:0] devDout;
    logic devDoutOeN;
    logic busWide;
    modport dev (input csN, rdN, wrN, strobeEnable, rdWrN, queueDirectSelect, addr,
        hostDout, hostDoutOeN, busWide, output devDout, devDoutOeN);
    modport host (output csN, rdN, wrN, strobeEnable, rdWrN, queueDirectSelect, addr,
        hostDout, hostDoutOeN, busWide, input devDout, devDoutOeN);
endinterface

// *** rtl/ihb_lane_swap.sv ***
`timescale 1ns/1ps
// maps a host lane to a little-endian dword lane and returns the byte enables
module ihb_lane_swap
    import ihb_pkg::*;
(
    input wire logic wide,
    input wire logic bigEnd,
    input wire logic [1:0] lowAddr,
    output logic [3:0] laneEn,
    output logic [1:0] laneBase
);
    logic [1:0] eff;
    // big endian mirrors the position inside the dword
    always_comb begin
        eff = bigEnd ? (wide ? {~lowAddr[1], 1'b0} : ~lowAddr) : lowAddr;
        if (wide) begin
            eff[0] = 1'b0;
            laneEn = eff[1] ? 4'hc : 4'h3;
        end else begin
            laneEn = 4'h1 << eff;
        end
        laneBase = eff;
    end
endmodule

// *** rtl/ihb_pkg.sv ***
package ihb_pkg;
    // host-visible byte offsets
    localparam logic [4:0] OFS_PTR0 = 5'h00;
    localparam logic [4:0] OFS_WIN0 = 5'h04;
    localparam logic [4:0] OFS_PTR1 = 5'h08;
    localparam logic [4:0] OFS_WIN1 = 5'h0c;
    localparam logic [4:0] OFS_PTR2 = 5'h10;
    localparam logic [4:0] OFS_WIN2 = 5'h14;
    localparam logic [4:0] OFS_QUEUE = 5'h18;
    localparam logic [4:0] OFS_CFG = 5'h1c;
    // configuration field layout: endian bit n is mirrored at n, n+8, n+16, n+24
    localparam int CFG_QUEUE_BIT = 3;
    localparam int CFG_SHADOW_STEP = 8;
    localparam logic [31:0] CFG_RW_MASK = 32'h0f0f0f0f;
    localparam logic [31:0] CFG_RESET = 32'h00000000;
    // pointer register layout
    localparam logic [15:0] PTR_RESET = 16'h1234;
    // assembly path index: 0..2 windows, 3 queue
    localparam logic [1:0] PATH_QUEUE = 2'h3;
    // internal write targets for the queue path
    localparam logic [15:0] QUEUE_IADDR = 16'h0000;
    // host command codes on the controller side
    localparam logic [3:0] CMD_ADDR_OFS = 4'h0;
    localparam logic [3:0] CMD_WDATA_OFS = 4'h4;
    localparam logic [3:0] CMD_CTRL_OFS = 4'h8;
    localparam logic [3:0] CMD_STAT_OFS = 4'hc;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_READ_BIT = 1;
    localparam int CTRL_WIDE_BIT = 2;
    localparam int CTRL_QSEL_BIT = 3;
    localparam int CTRL_ENB_BIT = 4;
    // strobe timing at 40 MHz
    localparam int CLK_MHZ = 40;
    localparam int T_STROBE_NS = 32;
    localparam int T_GAP_NS = 13;
    localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int GAP_CYC = (T_GAP_NS * CLK_MHZ + 999) / 1000;
endpackage

// *** testbench/ihb_properties.sv ***
`timescale 1ns/1ps
// --------------------------------
// wire checks between host and device
// --------------------------------
module ihb_properties
    import ihb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic csN,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic queueDirectSelect,
    input wire logic [4:0] addr,
    input wire logic [15:0] hostDout,
    input wire logic hostDoutOeN,
    input wire logic devDoutOeN
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // inside a write strobe, past its first cycle
    sequence s_wr_mid;
        !wrN && !$fell(wrN);
    endsequence
    sequence s_rd_end;
        $rose(rdN);
    endsequence

    property p_cs_qual;
        (!wrN || !rdN) |-> !csN;
    endproperty
    property p_one_strobe;
        !(!wrN && !rdN);
    endproperty
    // a two cycle minimum keeps the device sync flops from missing it
    property p_wr_width;
        $fell(wrN) |-> !wrN [*2];
    endproperty
    property p_rd_width;
        $fell(rdN) |-> !rdN [*2];
    endproperty
    property p_wr_addr_stable;
        s_wr_mid |-> $stable(addr) && $stable(queueDirectSelect);
    endproperty
    property p_wr_data_held;
        s_wr_mid |-> $stable(hostDout) && !hostDoutOeN;
    endproperty
    property p_no_contention;
        !(!hostDoutOeN && !devDoutOeN);
    endproperty
    property p_dev_release;
        s_rd_end |-> ##[0:6] devDoutOeN;
    endproperty

    a_cs_qual: assert property (p_cs_qual) else $error("strobe without chip select");
    a_one_strobe: assert property (p_one_strobe) else $error("read and write together");
    a_wr_width: assert property (p_wr_width) else $error("write strobe too short");
    a_rd_width: assert property (p_rd_width) else $error("read strobe too short");
    a_wr_addr_stable: assert property (p_wr_addr_stable) else $error("address moved");
    a_wr_data_held: assert property (p_wr_data_held) else $error("write data moved");
    a_no_contention: assert property (p_no_contention) else $error("data bus contention");
    a_dev_release: assert property (p_dev_release) else $error("device kept bus");
endmodule

// *** testbench/ihb_tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) check_val(g, e)
module ihb_tb
    import ihb_pkg::*;
;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic initDone = 1'b1;
    logic fullyOnPowerState = 1'b1;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic [31:0] regRdata, endianConfig, intWrData, q;
    logic [15:0] intWrAddr;
    logic intWrValid, intWrQueue, writesArmed;
    logic wideMode = 1'b1;
    logic qSel = 1'b0;
    logic enbMode = 1'b0;
    int num_errors = 0;
    int tests_run = 0;
    logic [31:0] gotData[$];
    logic [16:0] gotAddr[$];

    ihb_if bus ();
    ihb_host i_ihb_host (.sys_clk(sys_clk), .resetn(resetn), .bus(bus), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
    ihb_device i_ihb_device (.sys_clk(sys_clk), .resetn(resetn), .bus(bus),
        .initDone(initDone), .fullyOnPowerState(fullyOnPowerState), .intWrValid(intWrValid),
        .intWrAddr(intWrAddr), .intWrData(intWrData), .intWrQueue(intWrQueue),
        .endianConfig(endianConfig), .writesArmed(writesArmed));
    ihb_properties i_ihb_properties (.sys_clk(sys_clk), .resetn(resetn), .csN(bus.csN),
        .rdN(bus.rdN), .wrN(bus.wrN), .queueDirectSelect(bus.queueDirectSelect),
        .addr(bus.addr), .hostDout(bus.hostDout), .hostDoutOeN(bus.hostDoutOeN),
        .devDoutOeN(bus.devDoutOeN));

    // --------------------------------
    // clock and internal write log
    // --------------------------------
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // one entry per internal write, so interleaved paths can be told apart
    always @(posedge sys_clk) begin
        if (intWrValid === 1'b1) begin
            gotData.push_back(intWrData);
            gotAddr.push_back({intWrQueue, intWrAddr});
        end
    end

    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
            num_errors++;
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    // read data stand from the cycle after the strobe until the next read
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        @(negedge sys_clk);
        d = regRdata;
    endtask
    // one strobed host cycle; the poll is bounded so a stuck host ends the run
    task automatic bus_op(input logic rd, input logic [4:0] a, input logic [15:0] d);
        logic [31:0] s;
        reg_wr(CMD_ADDR_OFS, {27'h0, a});
        reg_wr(CMD_WDATA_OFS, {16'h0, d});
        reg_wr(CMD_CTRL_OFS, {27'h0, enbMode, qSel, wideMode, rd, 1'b1});
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i <= 60; i++) begin
            reg_rd(CMD_STAT_OFS, s);
            if (s[0] === 1'b0) break;
            if (i == 60) begin
                num_errors++;
                report_and_stop();
            end
        end
        repeat (8) @(posedge sys_clk);
        if (rd) reg_rd(CMD_WDATA_OFS, q);
    endtask
    task automatic pulse(input int n, input logic [16:0] a, input logic [31:0] d);
        `CHK(gotData.size(), n);
        if (gotData.size() == n && n > 0) begin
            `CHK(gotAddr[n-1], a);
            `CHK(gotData[n-1], d);
        end
    endtask

    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_lock();
        `CHK(writesArmed, 1'b0);
        `CHK(endianConfig, CFG_RESET);
        bus_op(0, 5'h1c, 16'h0001);
        `CHK(endianConfig, CFG_RESET);
        bus_op(1, 5'h00, 16'h0);
        `CHK(q[15:0], PTR_RESET);
        `CHK(writesArmed, 1'b1);
        $display("test lock done");
    endtask
    task automatic t_cfg();
        bus_op(0, 5'h1c, 16'h0800);
        `CHK(endianConfig, 32'h08080808);
        bus_op(0, 5'h1e, 16'h0002);
        `CHK(endianConfig, 32'h0a0a0a0a);
        $display("test config done");
    endtask
    task automatic t_windows();
        bus_op(0, 5'h00, 16'h0040);
        bus_op(0, 5'h06, 16'hbeef);
        pulse(0, 17'h0, 32'h0);
        bus_op(0, 5'h04, 16'hdead);
        pulse(1, 17'h00040, 32'hbeefdead);
        // pair 1 is big endian: its pointer is the word at offset 2, bytes swapped
        bus_op(0, 5'h0a, 16'h8000);
        bus_op(0, 5'h0c, 16'h1122);
        bus_op(0, 5'h0e, 16'h3344);
        pulse(2, 17'h00080, 32'h22114433);
        $display("test windows done");
    endtask
    // window 0 and the queue interleaved, queue reached both ways
    task automatic t_mix();
        bus_op(0, 5'h04, 16'h5555);
        qSel = 1'b1;
        bus_op(0, 5'h00, 16'haabb);
        qSel = 1'b0;
        bus_op(0, 5'h06, 16'h6666);
        pulse(3, 17'h00040, 32'h66665555);
        bus_op(0, 5'h1a, 16'hccdd);
        pulse(4, {1'b1, QUEUE_IADDR}, 32'hbbaaddcc);
        $display("test mix done");
    endtask
    task automatic t_byte();
        wideMode = 1'b0;
        bus_op(0, 5'h10, 16'h00c4);
        bus_op(0, 5'h11, 16'h0000);
        bus_op(0, 5'h17, 16'h0044);
        bus_op(0, 5'h14, 16'h0011);
        bus_op(0, 5'h16, 16'h0033);
        pulse(4, {1'b1, QUEUE_IADDR}, 32'hbbaaddcc);
        bus_op(0, 5'h15, 16'h0022);
        pulse(5, 17'h000c4, 32'h44332211);
        wideMode = 1'b1;
        $display("test byte done");
    endtask
    task automatic t_power();
        bus_op(0, 5'h04, 16'h7777);
        @(posedge sys_clk);
        fullyOnPowerState <= 1'b0;
        repeat (6) @(posedge sys_clk);
        fullyOnPowerState <= 1'b1;
        repeat (4) @(posedge sys_clk);
        `CHK(writesArmed, 1'b0);
        bus_op(0, 5'h06, 16'h1111);
        pulse(5, 17'h000c4, 32'h44332211);
        bus_op(1, 5'h00, 16'h0);
        bus_op(0, 5'h04, 16'h2222);
        pulse(5, 17'h000c4, 32'h44332211);
        bus_op(0, 5'h06, 16'h3333);
        pulse(6, 17'h00040, 32'h33332222);
        $display("test power done");
    endtask
    task automatic t_init();
        @(posedge sys_clk);
        initDone <= 1'b0;
        repeat (4) @(posedge sys_clk);
        initDone <= 1'b1;
        repeat (6) @(posedge sys_clk);
        `CHK(writesArmed, 1'b0);
        bus_op(0, 5'h1c, 16'h0004);
        `CHK(endianConfig, 32'h0a0a0a0a);
        // enable-with-direction style: a read arms writes, then one window dword
        enbMode = 1'b1;
        bus_op(1, 5'h00, 16'h0);
        `CHK(q, 32'h00000040);
        `CHK(writesArmed, 1'b1);
        bus_op(0, 5'h04, 16'h0102);
        bus_op(0, 5'h06, 16'h0304);
        pulse(7, 17'h00040, 32'h03040102);
        enbMode = 1'b0;
        $display("test init done");
    endtask

    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_lock();
        t_cfg();
        t_windows();
        t_mix();
        t_byte();
        t_power();
        t_init();
        report_and_stop();
    end
endmodule
